// file: include/sau_pkg.sv
package sau_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int CACHE_DEPTH = 4;
    localparam int CNT_W = 3;
    localparam int OP_W = 4;
    localparam int DISP_W = 9;
    localparam int DIV_STEPS = 16;
    localparam int DIV_CNT_W = 5;

    // Instruction word fields
    localparam int LOAD_FLAG_BIT = 15;
    localparam int FIRST_OP_LSB = 4;
    localparam int SECOND_OP_LSB = 0;
    localparam int DISP_LSB = 0;

    // Element counts
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_MIN_BINARY = 3'h2;
    localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
    localparam logic [ADDR_W-1:0] SPILL_DEPTH = 16'h0003;

    typedef enum logic [OP_W-1:0] {
        SAU_OP_NONE = 4'h0,
        SAU_OP_POP_DISCARD = 4'h1,
        SAU_OP_ADD = 4'h2,
        SAU_OP_MULTIPLY = 4'h3,
        SAU_OP_SUBTRACT = 4'h4,
        SAU_OP_SIGN_INVERT = 4'h5,
        SAU_OP_DIVIDE = 4'h6
    } sau_op_t;

    typedef enum logic [1:0] {
        SAU_MEM_FETCH,
        SAU_MEM_SPILL,
        SAU_MEM_LOAD
    } sau_mem_kind_t;
endpackage : sau_pkg

// file: logic/sau_divider.sv
`timescale 1ns/1ps
module sau_divider (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [sau_pkg::WORD_W-1:0] dividend_i,
    input wire logic [sau_pkg::WORD_W-1:0] divisor_i,
    output logic done_o,
    output logic [sau_pkg::WORD_W-1:0] quotient_o,
    output logic [sau_pkg::WORD_W-1:0] remainder_o
);
    import sau_pkg::*;

    logic busy_reg;
    logic [DIV_CNT_W-1:0] step_reg;
    logic [WORD_W-1:0] quot_reg;
    logic [WORD_W:0] rem_reg;
    logic [WORD_W-1:0] dvsr_reg;
    logic [WORD_W:0] trial;

    // Restoring division, one quotient bit a cycle
    assign trial = {rem_reg[WORD_W-1:0], quot_reg[WORD_W-1]} - {1'b0, dvsr_reg};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_reg <= 1'b0;
            step_reg <= '0;
            quot_reg <= '0;
            rem_reg <= '0;
            dvsr_reg <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_reg) begin
                busy_reg <= 1'b1;
                step_reg <= DIV_CNT_W'(DIV_STEPS);
                quot_reg <= dividend_i;
                rem_reg <= '0;
                dvsr_reg <= divisor_i;
            end else if (busy_reg) begin
                if (trial[WORD_W]) begin
                    rem_reg <= {rem_reg[WORD_W-1:0], quot_reg[WORD_W-1]};
                    quot_reg <= {quot_reg[WORD_W-2:0], 1'b0};
                end else begin
                    rem_reg <= trial;
                    quot_reg <= {quot_reg[WORD_W-2:0], 1'b1};
                end
                step_reg <= step_reg - 1'b1;
                if (step_reg == DIV_CNT_W'(1)) begin
                    busy_reg <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign quotient_o = quot_reg;
    assign remainder_o = rem_reg[WORD_W-1:0];
endmodule : sau_divider

// file: logic/sau_stack_unit.sv
`timescale 1ns/1ps
// Behaviour
// - Keep a top-of-stack pointer on the top element and a frame base pointer.
// - Discarding the top only lowers the stack pointer by one, no memory write.
// - Load copies a memory word just above the top, then raises the pointer.
// - Only the load word carries an address, relative to the frame base.
// - Arithmetic ops take operands from the top; no address field in them.
// - Add replaces the two top elements with their sum, pointer drops one.
// - Multiply replaces the two top elements with their product.
// - Subtract takes top from next-to-top, leaving the difference on top.
// - Sign invert negates the top in place, pointer unchanged.
// - Up to four top elements are held in internal registers.
// - Two-operand ops fetch from memory until two elements are cached.
// - One instruction word may carry two stack ops run in sequence.
// - Divide leaves quotient below and remainder on top.
module sau_stack_unit (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic set_ptr_i,
    input wire logic [sau_pkg::ADDR_W-1:0] sp_init_i,
    input wire logic [sau_pkg::ADDR_W-1:0] fb_init_i,
    input wire logic instr_valid_i,
    input wire logic [sau_pkg::WORD_W-1:0] instr_i,
    output logic instr_ready_o,
    output logic [sau_pkg::ADDR_W-1:0] sp_o,
    output logic [sau_pkg::ADDR_W-1:0] fb_o,
    output logic [sau_pkg::WORD_W-1:0] top_o,
    output logic [sau_pkg::CNT_W-1:0] top_register_count_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [sau_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [sau_pkg::WORD_W-1:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [sau_pkg::WORD_W-1:0] mem_rdata_i
);
    import sau_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_MEM_WAIT, ST_DIV_WAIT} sau_state_t;

    function automatic logic [ADDR_W-1:0] sau_below(input logic [ADDR_W-1:0] sp, input logic [ADDR_W-1:0] depth);
        sau_below = sp - depth;
    endfunction : sau_below

    function automatic logic [ADDR_W-1:0] sau_sext(input logic [DISP_W-1:0] disp);
        sau_sext = {{(ADDR_W-DISP_W){disp[DISP_W-1]}}, disp};
    endfunction : sau_sext

    sau_state_t state_reg;
    sau_mem_kind_t kind_reg;
    logic [ADDR_W-1:0] sp_reg;
    logic [ADDR_W-1:0] fb_reg;
    logic [CNT_W-1:0] top_register_count_reg;
    logic [WORD_W-1:0] cache_reg [CACHE_DEPTH];
    logic is_load_reg;
    logic [DISP_W-1:0] disp_reg;
    sau_op_t op_first_reg;
    sau_op_t op_second_reg;
    logic slot_reg;
    logic ready_reg;
    logic mem_req_reg;
    logic mem_we_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic [WORD_W-1:0] mem_wdata_reg;

    sau_op_t cur_op;
    logic need_fetch;
    logic issue_mem;
    logic issue_we;
    logic [ADDR_W-1:0] issue_addr;
    sau_mem_kind_t issue_kind;
    logic exec_now;
    logic div_start;
    logic div_done;
    logic [WORD_W-1:0] div_quot;
    logic [WORD_W-1:0] div_rem;
    logic [2*WORD_W-1:0] product;
    logic accept;
    logic op_binary;

    assign accept = ready_reg && instr_valid_i && !set_ptr_i;
    assign cur_op = slot_reg ? op_second_reg : op_first_reg;
    assign product = (2*WORD_W)'(cache_reg[1]) * (2*WORD_W)'(cache_reg[0]);
    assign op_binary = (cur_op == SAU_OP_ADD) || (cur_op == SAU_OP_MULTIPLY)
                    || (cur_op == SAU_OP_SUBTRACT) || (cur_op == SAU_OP_DIVIDE);

    // Decide per cycle whether the current op needs memory first
    always_comb begin
        need_fetch = 1'b0;
        issue_mem = 1'b0;
        issue_we = 1'b0;
        issue_addr = '0;
        issue_kind = SAU_MEM_FETCH;
        exec_now = 1'b0;
        div_start = 1'b0;
        if (state_reg == ST_EXEC) begin
            if (is_load_reg) begin
                issue_mem = 1'b1;
                if (top_register_count_reg == CNT_FULL) begin
                    // Make room by spilling the oldest cached element
                    issue_we = 1'b1;
                    issue_addr = sau_below(sp_reg, SPILL_DEPTH);
                    issue_kind = SAU_MEM_SPILL;
                end else begin
                    issue_addr = fb_reg + sau_sext(disp_reg);
                    issue_kind = SAU_MEM_LOAD;
                end
            end else begin
                need_fetch = (op_binary && top_register_count_reg < CNT_MIN_BINARY)
                          || (cur_op == SAU_OP_SIGN_INVERT && top_register_count_reg < CNT_ONE);
                if (need_fetch) begin
                    issue_mem = 1'b1;
                    issue_addr = sau_below(sp_reg, ADDR_W'(top_register_count_reg));
                    issue_kind = SAU_MEM_FETCH;
                end else if (cur_op == SAU_OP_DIVIDE) begin
                    div_start = 1'b1;
                end else begin
                    exec_now = 1'b1;
                end
            end
        end
    end

    // Stack state, cache and sequencing
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_IDLE;
            kind_reg <= SAU_MEM_FETCH;
            sp_reg <= '0;
            fb_reg <= '0;
            top_register_count_reg <= CNT_ZERO;
            for (int i = 0; i < CACHE_DEPTH; i++) begin
                cache_reg[i] <= '0;
            end
            is_load_reg <= 1'b0;
            disp_reg <= '0;
            op_first_reg <= SAU_OP_NONE;
            op_second_reg <= SAU_OP_NONE;
            slot_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    ready_reg <= 1'b1;
                    if (ready_reg && set_ptr_i) begin
                        sp_reg <= sp_init_i;
                        fb_reg <= fb_init_i;
                        top_register_count_reg <= CNT_ZERO;
                    end else if (accept) begin
                        ready_reg <= 1'b0;
                        state_reg <= ST_EXEC;
                        slot_reg <= 1'b0;
                        is_load_reg <= instr_i[LOAD_FLAG_BIT];
                        disp_reg <= instr_i[DISP_LSB +: DISP_W];
                        // Pair word: two implicit-operand ops, no address field
                        op_first_reg <= sau_op_t'(instr_i[FIRST_OP_LSB +: OP_W]);
                        op_second_reg <= sau_op_t'(instr_i[SECOND_OP_LSB +: OP_W]);
                    end
                end
                ST_EXEC: begin
                    if (issue_mem) begin
                        kind_reg <= issue_kind;
                        state_reg <= ST_MEM_WAIT;
                    end else if (div_start) begin
                        state_reg <= ST_DIV_WAIT;
                    end else begin
                        case (cur_op)
                            SAU_OP_POP_DISCARD: begin
                                sp_reg <= sp_reg - ADDR_ONE;
                                if (top_register_count_reg != CNT_ZERO) begin
                                    top_register_count_reg <= top_register_count_reg - CNT_ONE;
                                    cache_reg[0] <= cache_reg[1];
                                    cache_reg[1] <= cache_reg[2];
                                    cache_reg[2] <= cache_reg[3];
                                end
                            end
                            SAU_OP_ADD, SAU_OP_MULTIPLY, SAU_OP_SUBTRACT: begin
                                if (cur_op == SAU_OP_ADD) begin
                                    cache_reg[0] <= cache_reg[1] + cache_reg[0];
                                end else if (cur_op == SAU_OP_MULTIPLY) begin
                                    // Low word of the product; overflow is not flagged
                                    cache_reg[0] <= product[WORD_W-1:0];
                                end else begin
                                    cache_reg[0] <= cache_reg[1] - cache_reg[0];
                                end
                                cache_reg[1] <= cache_reg[2];
                                cache_reg[2] <= cache_reg[3];
                                sp_reg <= sp_reg - ADDR_ONE;
                                top_register_count_reg <= top_register_count_reg - CNT_ONE;
                            end
                            SAU_OP_SIGN_INVERT: begin
                                cache_reg[0] <= '0 - cache_reg[0];
                            end
                            default: begin
                            end
                        endcase
                        if (!slot_reg && !is_load_reg && op_second_reg != SAU_OP_NONE) begin
                            slot_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_MEM_WAIT: begin
                    if (mem_ack_i) begin
                        state_reg <= ST_EXEC;
                        case (kind_reg)
                            SAU_MEM_FETCH: begin
                                cache_reg[top_register_count_reg[1:0]] <= mem_rdata_i;
                                top_register_count_reg <= top_register_count_reg + CNT_ONE;
                            end
                            SAU_MEM_SPILL: begin
                                top_register_count_reg <= top_register_count_reg - CNT_ONE;
                            end
                            SAU_MEM_LOAD: begin
                                cache_reg[0] <= mem_rdata_i;
                                cache_reg[1] <= cache_reg[0];
                                cache_reg[2] <= cache_reg[1];
                                cache_reg[3] <= cache_reg[2];
                                sp_reg <= sp_reg + ADDR_ONE;
                                top_register_count_reg <= top_register_count_reg + CNT_ONE;
                                state_reg <= ST_IDLE;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_DIV_WAIT: begin
                    if (div_done) begin
                        cache_reg[0] <= div_rem;
                        cache_reg[1] <= div_quot;
                        if (!slot_reg && op_second_reg != SAU_OP_NONE) begin
                            slot_reg <= 1'b1;
                            state_reg <= ST_EXEC;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Memory port holds its request until acknowledged
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= '0;
            mem_wdata_reg <= '0;
        end else if (issue_mem) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= issue_we;
            mem_addr_reg <= issue_addr;
            mem_wdata_reg <= cache_reg[CACHE_DEPTH-1];
        end else if (mem_ack_i) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
        end
    end

    sau_divider u_divider (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .start_i(div_start),
        .dividend_i(cache_reg[1]),
        .divisor_i(cache_reg[0]),
        .done_o(div_done),
        .quotient_o(div_quot),
        .remainder_o(div_rem)
    );

    assign instr_ready_o = ready_reg;
    assign sp_o = sp_reg;
    assign fb_o = fb_reg;
    assign top_o = cache_reg[0];
    assign top_register_count_o = top_register_count_reg;
    assign mem_req_o = mem_req_reg;
    assign mem_we_o = mem_we_reg;
    assign mem_addr_o = mem_addr_reg;
    assign mem_wdata_o = mem_wdata_reg;

    AST_DISCARD_DROPS_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_now && cur_op == SAU_OP_POP_DISCARD |=> sp_reg == $past(sp_reg) - ADDR_ONE && !mem_req_reg)
        else $error("discard did not lower the pointer by one without memory access");
    AST_LOAD_PUSHES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == ST_MEM_WAIT && kind_reg == SAU_MEM_LOAD && mem_ack_i
        |=> sp_reg == $past(sp_reg) + ADDR_ONE && cache_reg[0] == $past(mem_rdata_i))
        else $error("load did not push the fetched word");
    AST_ADD_RESULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_now && cur_op == SAU_OP_ADD
        |=> cache_reg[0] == $past(cache_reg[1]) + $past(cache_reg[0]) && sp_reg == $past(sp_reg) - ADDR_ONE)
        else $error("add result or pointer wrong");
    AST_MUL_RESULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_now && cur_op == SAU_OP_MULTIPLY |=> cache_reg[0] == $past(cache_reg[1]) * $past(cache_reg[0])
        && top_register_count_reg == $past(top_register_count_reg) - CNT_ONE)
        else $error("multiply result or count wrong");
    AST_SUB_RESULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_now && cur_op == SAU_OP_SUBTRACT |=> cache_reg[0] == $past(cache_reg[1]) - $past(cache_reg[0]))
        else $error("subtract order wrong");
    AST_NEGATE_IN_PLACE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_now && cur_op == SAU_OP_SIGN_INVERT |=> cache_reg[0] == '0 - $past(cache_reg[0]) && $stable(sp_reg))
        else $error("sign invert wrong");
    AST_CACHE_BOUND: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        top_register_count_reg <= CNT_FULL)
        else $error("cached count above four");
    AST_OPERANDS_CACHED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_now || div_start) && op_binary |-> top_register_count_reg >= CNT_MIN_BINARY)
        else $error("two-operand op ran without two cached operands");
    AST_DIV_ORDER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        div_start |-> ##[17:18] state_reg != ST_DIV_WAIT && cache_reg[0] == div_rem)
        else $error("divide did not finish with remainder on top");
    AST_PAIR_COMPLETES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        accept && !instr_i[LOAD_FLAG_BIT] && instr_i[SECOND_OP_LSB +: OP_W] != SAU_OP_NONE
        |=> slot_reg == 1'b0 ##[1:300] slot_reg)
        else $error("second packed op never started");
    AST_FETCH_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == ST_MEM_WAIT && kind_reg == SAU_MEM_FETCH && mem_ack_i
        |=> top_register_count_reg == $past(top_register_count_reg) + CNT_ONE)
        else $error("fetch did not raise the cached count");
endmodule : sau_stack_unit

// file: bench/sau_mem_model.sv
`timescale 1ns/1ps
module sau_mem_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [0:255];
    logic [3:0] wait_reg;
    logic hit;

    assign hit = req_i && !ack_o && (wait_reg == delay_i);

    // Outside an ack the read bus toggles so stale data is never mistaken for an answer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_o <= 1'b0;
            wait_reg <= 4'h0;
            rdata_o <= 16'h5a5a;
        end else if (hit) begin
            ack_o <= 1'b1;
            rdata_o <= mem[addr_i[7:0]];
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            wait_reg <= (req_i && !ack_o) ? wait_reg + 4'h1 : 4'h0;
        end
    end

    // Plain process: the bench preloads this array directly
    always @(posedge clk_i) begin
        if (hit && we_i) begin
            mem[addr_i[7:0]] <= wdata_i;
        end
    end
endmodule : sau_mem_model

// file: bench/stack_arithmetic_unit_bench.sv
`timescale 1ns/1ps
`define SAU_CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module stack_arithmetic_unit_bench;
    import sau_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic set_ptr = 1'b0;
    logic [15:0] sp_init = 16'h0000;
    logic [15:0] fb_init = 16'h0000;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] mem_delay = 4'h0;
    logic instr_ready, mem_req, mem_we, mem_ack;
    logic [15:0] sp, fb, top, mem_addr, mem_wdata, mem_rdata;
    logic [2:0] cnt;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int acc_cnt = 0;
    int wr_cnt = 0;

    always #12.5 clk = ~clk;

    sau_stack_unit DUT (.clk_i(clk), .rst_b_i(rst_b), .set_ptr_i(set_ptr), .sp_init_i(sp_init),
        .fb_init_i(fb_init), .instr_valid_i(instr_valid), .instr_i(instr), .instr_ready_o(instr_ready),
        .sp_o(sp), .fb_o(fb), .top_o(top), .top_register_count_o(cnt), .mem_req_o(mem_req),
        .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata));

    sau_mem_model mem_u (.clk_i(clk), .rst_b_i(rst_b), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
        .wdata_i(mem_wdata), .delay_i(mem_delay), .ack_o(mem_ack), .rdata_o(mem_rdata));

    always @(posedge clk) begin
        if (mem_req && mem_ack) begin
            acc_cnt++;
            wr_cnt += mem_we ? 1 : 0;
        end
    end

    task automatic stop_test();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // Bounded run: every scenario finishes in a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic wait_ready();
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        // A word that never completes ends the run as a failure
        if (instr_ready !== 1'b1) begin
            err_total++;
            stop_test();
        end
    endtask : wait_ready

    task automatic issue(input logic [15:0] w);
        wait_ready();
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        wait_ready();
    endtask : issue

    task automatic set_ptrs(input logic [15:0] s, input logic [15:0] f);
        wait_ready();
        @(posedge clk);
        set_ptr <= 1'b1;
        sp_init <= s;
        fb_init <= f;
        @(posedge clk);
        set_ptr <= 1'b0;
        #1;
        wait_ready();
    endtask : set_ptrs

    function automatic logic [15:0] ld(input logic [8:0] d);
        return {7'h40, d};
    endfunction : ld

    function automatic logic [15:0] pr(input sau_op_t a, input sau_op_t b);
        return {8'h00, a, b};
    endfunction : pr

    task automatic chk3(input logic [15:0] t, input logic [15:0] s, input logic [2:0] c);
        `SAU_CHK(top, t)
        `SAU_CHK(sp, s)
        `SAU_CHK(cnt, c)
    endtask : chk3

    task automatic t_discard_empty();
        int a;
        set_ptrs(16'h0010, 16'h0000);
        a = acc_cnt;
        issue(pr(SAU_OP_POP_DISCARD, SAU_OP_NONE));
        `SAU_CHK(sp, 16'h000f)
        `SAU_CHK(acc_cnt, a)
        // Pointer load and an offered word in one cycle: the pointer load wins
        @(posedge clk);
        set_ptr <= 1'b1;
        sp_init <= 16'h0020;
        instr_valid <= 1'b1;
        instr <= pr(SAU_OP_POP_DISCARD, SAU_OP_NONE);
        @(posedge clk);
        set_ptr <= 1'b0;
        instr_valid <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `SAU_CHK(sp, 16'h0020)
        `SAU_CHK(instr_ready, 1'b1)
    endtask : t_discard_empty

    task automatic t_load();
        mem_u.mem[8'h23] = 16'h0063;
        mem_u.mem[8'h1e] = 16'h0025;
        set_ptrs(16'h0030, 16'h0020);
        `SAU_CHK(fb, 16'h0020)
        issue(ld(9'h003));
        chk3(16'h0063, 16'h0031, 3'h1);
        issue(ld(9'h1fe));
        chk3(16'h0025, 16'h0032, 3'h2);
    endtask : t_load

    task automatic t_arith();
        mem_u.mem[8'h20] = 16'h0007;
        mem_u.mem[8'h21] = 16'h0063;
        mem_u.mem[8'h22] = 16'h0025;
        mem_u.mem[8'h23] = 16'h01f4;
        set_ptrs(16'h0040, 16'h0020);
        issue(ld(9'h000));
        issue(ld(9'h001));
        issue(ld(9'h002));
        issue(pr(SAU_OP_ADD, SAU_OP_MULTIPLY));
        chk3(16'h03b8, 16'h0041, 3'h1);
        issue(ld(9'h003));
        issue(pr(SAU_OP_SUBTRACT, SAU_OP_NONE));
        chk3(16'h01c4, 16'h0041, 3'h1);
        issue(pr(SAU_OP_SIGN_INVERT, SAU_OP_NONE));
        chk3(16'hfe3c, 16'h0041, 3'h1);
    endtask : t_arith

    task automatic t_divide();
        mem_u.mem[8'h48] = 16'h0019;
        mem_u.mem[8'h49] = 16'h000a;
        mem_u.mem[8'h4a] = 16'h0000;
        set_ptrs(16'h0050, 16'h0048);
        issue(ld(9'h000));
        issue(ld(9'h001));
        issue(pr(SAU_OP_DIVIDE, SAU_OP_NONE));
        chk3(16'h0005, 16'h0052, 3'h2);
        issue(pr(SAU_OP_POP_DISCARD, SAU_OP_NONE));
        chk3(16'h0002, 16'h0051, 3'h1);
        // Divide by zero gives all ones, then the packed discard drops the remainder
        issue(ld(9'h000));
        issue(ld(9'h002));
        issue(pr(SAU_OP_DIVIDE, SAU_OP_POP_DISCARD));
        chk3(16'hffff, 16'h0052, 3'h2);
    endtask : t_divide

    task automatic t_fetch();
        int a;
        int w;
        mem_u.mem[8'h70] = 16'h1234;
        mem_u.mem[8'h6f] = 16'h0101;
        mem_u.mem[8'h6e] = 16'h0003;
        set_ptrs(16'h0070, 16'h0000);
        `SAU_CHK(cnt, 3'h0)
        mem_delay <= 4'h3;
        a = acc_cnt;
        w = wr_cnt;
        issue(pr(SAU_OP_SUBTRACT, SAU_OP_NONE));
        chk3(16'heecd, 16'h006f, 3'h1);
        `SAU_CHK(acc_cnt - a, 2)
        `SAU_CHK(wr_cnt, w)
        // Sign invert on an empty cache fetches its one operand first
        issue(pr(SAU_OP_POP_DISCARD, SAU_OP_SIGN_INVERT));
        chk3(16'hfffd, 16'h006e, 3'h1);
        `SAU_CHK(acc_cnt - a, 3)
        mem_delay <= 4'h0;
    endtask : t_fetch

    task automatic t_spill();
        int w;
        for (int i = 0; i < 5; i++) begin
            mem_u.mem[8'h80 + i] = 16'h00a0 + 16'(i);
        end
        set_ptrs(16'h0090, 16'h0080);
        for (int i = 0; i < 4; i++) begin
            issue(ld(9'(i)));
        end
        chk3(16'h00a3, 16'h0094, 3'h4);
        w = wr_cnt;
        issue(ld(9'h004));
        chk3(16'h00a4, 16'h0095, 3'h4);
        `SAU_CHK(wr_cnt - w, 1)
        `SAU_CHK(mem_u.mem[8'h91], 16'h00a0)
    endtask : t_spill

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_discard_empty();
        t_load();
        t_arith();
        t_divide();
        t_fetch();
        t_spill();
        stop_test();
    end
endmodule : stack_arithmetic_unit_bench
